// File: rtl/pwm_seq_pkg.sv
// Constants, types and timing figures of the multiphase phase sequencer.
// Assumes one 100 MHz clock and a period given in clock cycles.
`default_nettype none

package pwm_seq_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int          NUM_PHASES   = 4;
  localparam int          PERIOD_W     = 16;
  localparam int          SENSE_W      = 12;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam real         CLK_PERIOD_NS = 10.0;
  localparam logic [15:0] MIN_PERIOD    = 16'h0006;
  localparam logic [15:0] CNT_SAT       = 16'hFFFF;
  localparam logic [15:0] CNT_STEP      = 16'h0001;
  localparam logic [15:0] THIRD_DIV     = 16'h0003;
  localparam logic [15:0] SIXTH_DIV     = 16'h0006;
  localparam int          QUARTER_SHIFT = 2;
  localparam int          HALF_SHIFT    = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0]        PERIOD_RST = 16'h0000;
  localparam logic [SENSE_W-1:0] SAMPLE_RST = 12'h000;

  // ****************************************************************
  // Channel count modes and sequencer states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    MODE_2CH = 3'b001,
    MODE_3CH = 3'b010,
    MODE_4CH = 3'b100
  } mode_t;

  typedef enum logic [1:0]
  {
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

  localparam logic [3:0] MASK_2CH = 4'h3;
  localparam logic [3:0] MASK_3CH = 4'h7;
  localparam logic [3:0] MASK_4CH = 4'hF;

endpackage

`default_nettype wire

// File: rtl/phase_channel.sv
// One phase channel: output level, forced off time, sample window, hold.
// Assumes a one-cycle termination pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none

module phase_channel
  import pwm_seq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               enable,
  input  wire logic               term,
  input  wire logic               trip,
  input  wire logic [15:0]        third_cnt,
  input  wire logic [15:0]        sixth_cnt,
  input  wire logic [SENSE_W-1:0] sense,
  output logic                    out_level,
  output logic                    window,
  output logic [SENSE_W-1:0]      held
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic               armed;
    logic               out;
    logic               win;
    logic [15:0]        cnt;
    logic [SENSE_W-1:0] smp;
    logic [SENSE_W-1:0] held;
  } ch_state_t;

  ch_state_t ch_reg;
  ch_state_t ch_next;
  logic      win_now;
  logic      off_done;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    ch_next  = ch_reg;
    off_done = (ch_reg.cnt >= third_cnt);
    win_now  = ch_reg.armed && !ch_reg.out && !term &&
               (ch_reg.cnt >= sixth_cnt) &&
               (16'(ch_reg.cnt - sixth_cnt) < third_cnt);
    if (!enable)
    begin
      ch_next = '0;
    end
    else
    begin
      if (ch_reg.cnt != CNT_SAT)
      begin
        ch_next.cnt = 16'(ch_reg.cnt + CNT_STEP);
      end
      if (term)
      begin
        ch_next.out   = 1'b0;
        ch_next.cnt   = '0;
        ch_next.armed = 1'b1;
      end
      else if (ch_reg.armed && !ch_reg.out && off_done && trip)
      begin
        ch_next.out = 1'b1;
      end
      ch_next.win = win_now;
      if (win_now)
      begin
        ch_next.smp = sense;
      end
      if (ch_reg.win && !win_now)
      begin
        ch_next.held = ch_reg.smp;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ch_reg <= '0;
    end
    else
    begin
      ch_reg <= ch_next;
    end
  end

  assign out_level = ch_reg.out;
  assign window    = ch_reg.win;
  assign held      = ch_reg.held;

endmodule

`default_nettype wire

// File: rtl/multiphase_pwm_sequencer.sv
// Interleaved phase sequencer for a two to four phase buck controller.
// Assumes comparator and sense inputs synchronous to CLK and a period
// in clock cycles from the frequency select circuit.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Active phases are spaced evenly over one switching period.
// - With neither phase 3 nor 4 tied high, four channels run.
// - A termination clock drops each phase; a cycle spans two drops.
// - Termination period equals the configured switching period.
// - Four channels terminate 4, 3, 2, 1, a quarter period apart.
// - Phase 4 tied high, phase 3 not: three channels 3, 2, 1, a third apart.
// - Phase 3 tied high: two channels, phase 2 half after phase 1.
// - A fallen output stays low at least one third period.
// - After forced off time, comparator trip drives the output high.
// - A high output stays high until its next termination.
// - Sample window opens at one sixth, closes a third later or at rise.
// - Each sample is held for one full switching cycle.
// - Held samples go to balance, load line and overcurrent logic.
// - Unused channels have sensing, sampling and output disabled.
module multiphase_pwm_sequencer
  import pwm_seq_pkg::*;
(
  input  wire logic                           CLK,
  input  wire logic                           RSTN,
  input  wire logic [pwm_seq_pkg::PERIOD_W-1:0] PERIOD_CYCLES,
  input  wire logic [3:0]                     CMP_TRIP,
  input  wire logic [pwm_seq_pkg::SENSE_W-1:0]  CURRENT_SENSE_INPUT_1,
  input  wire logic [pwm_seq_pkg::SENSE_W-1:0]  CURRENT_SENSE_INPUT_2,
  input  wire logic [pwm_seq_pkg::SENSE_W-1:0]  CURRENT_SENSE_INPUT_3,
  input  wire logic [pwm_seq_pkg::SENSE_W-1:0]  CURRENT_SENSE_INPUT_4,
  input  wire logic                           PHASE_IN_3,
  input  wire logic                           PHASE_IN_4,
  output logic                                PHASE_OUT_1,
  output logic                                PHASE_OUT_2,
  output logic                                PHASE_OUT_3,
  output logic                                PHASE_OUT_4,
  output logic                                PHASE_OE_3,
  output logic                                PHASE_OE_4,
  output logic [3:0]                          CHANNEL_ACTIVE,
  output logic [3:0]                          SAMPLE_WINDOW,
  output logic [pwm_seq_pkg::SENSE_W-1:0]       SENSED_CHANNEL_CURRENT_1,
  output logic [pwm_seq_pkg::SENSE_W-1:0]       SENSED_CHANNEL_CURRENT_2,
  output logic [pwm_seq_pkg::SENSE_W-1:0]       SENSED_CHANNEL_CURRENT_3,
  output logic [pwm_seq_pkg::SENSE_W-1:0]       SENSED_CHANNEL_CURRENT_4
);

  import pwm_seq_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [3:0] mode_mask(input mode_t m);
    logic [3:0] mask;
    begin
      mask = MASK_4CH;
      unique case (m)
        MODE_2CH:
        begin
          mask = MASK_2CH;
        end
        MODE_3CH:
        begin
          mask = MASK_3CH;
        end
        MODE_4CH:
        begin
          mask = MASK_4CH;
        end
        default:
        begin
          mask = MASK_4CH;
        end
      endcase
      mode_mask = mask;
    end
  endfunction

  // Termination point of channel ch (0 is phase 1) within the period
  function automatic logic [15:0] term_offset(input mode_t m,
                                              input int    ch,
                                              input logic [15:0] p);
    logic [15:0] q;
    logic [15:0] t;
    logic [15:0] h;
    logic [15:0] off;
    begin
      q   = p >> QUARTER_SHIFT;
      t   = p / THIRD_DIV;
      h   = p >> HALF_SHIFT;
      off = '0;
      unique case (m)
        MODE_4CH:
        begin
          // Order 4, 3, 2, 1 in quarter steps
          off = 16'(q * 16'(3 - ch));
        end
        MODE_3CH:
        begin
          // Order 3, 2, 1 in third steps
          off = (ch < 3) ? 16'(t * 16'(2 - ch)) : '0;
        end
        MODE_2CH:
        begin
          // Phase 2 half a period after phase 1
          off = (ch == 1) ? h : '0;
        end
        default:
        begin
          off = '0;
        end
      endcase
      term_offset = off;
    end
  endfunction

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef struct packed
  {
    seq_state_t  state;
    mode_t       mode;
    logic [15:0] per;
    logic [15:0] cnt;
  } seq_t;

  seq_t        seq_reg;
  seq_t        seq_next;
  logic [15:0] per_clamped;
  logic [15:0] third_cnt;
  logic [15:0] sixth_cnt;
  logic [3:0]  active;
  logic [3:0]  term;
  logic [3:0]  ch_out;
  logic [3:0]  ch_win;
  logic [SENSE_W-1:0] sense_arr [NUM_PHASES];
  logic [SENSE_W-1:0] held_arr  [NUM_PHASES];

  assign per_clamped = (PERIOD_CYCLES < MIN_PERIOD) ? MIN_PERIOD
                                                    : PERIOD_CYCLES;
  assign third_cnt   = seq_reg.per / THIRD_DIV;
  assign sixth_cnt   = seq_reg.per / SIXTH_DIV;
  assign active      = (seq_reg.state == ST_RUN) ? mode_mask(seq_reg.mode)
                                                 : 4'h0;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    seq_next = seq_reg;
    unique case (seq_reg.state)
      ST_CAPTURE:
      begin
        // Straps sampled once at the first edge after reset release
        if (PHASE_IN_3)
        begin
          seq_next.mode = MODE_2CH;
        end
        else if (PHASE_IN_4)
        begin
          seq_next.mode = MODE_3CH;
        end
        else
        begin
          seq_next.mode = MODE_4CH;
        end
        seq_next.state = ST_RUN;
        seq_next.per   = per_clamped;
        seq_next.cnt   = '0;
      end
      ST_RUN:
      begin
        // Period counter; new period taken only at the wrap
        if (seq_reg.cnt >= 16'(seq_reg.per - CNT_STEP))
        begin
          seq_next.cnt = '0;
          seq_next.per = per_clamped;
        end
        else
        begin
          seq_next.cnt = 16'(seq_reg.cnt + CNT_STEP);
        end
      end
      default:
      begin
        seq_next.state = ST_CAPTURE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      seq_reg.state <= ST_CAPTURE;
      seq_reg.mode  <= MODE_4CH;
      seq_reg.per   <= PERIOD_RST;
      seq_reg.cnt   <= '0;
    end
    else
    begin
      seq_reg <= seq_next;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  assign sense_arr[0] = CURRENT_SENSE_INPUT_1;
  assign sense_arr[1] = CURRENT_SENSE_INPUT_2;
  assign sense_arr[2] = CURRENT_SENSE_INPUT_3;
  assign sense_arr[3] = CURRENT_SENSE_INPUT_4;

  generate
    for (genvar g = 0; g < NUM_PHASES; g++)
    begin : g_ch
      // One pulse per period at this channel's spaced offset
      assign term[g] = active[g] &&
                       (seq_reg.cnt == term_offset(seq_reg.mode, g,
                                                   seq_reg.per));

      phase_channel u_ch
      (
        .clk       (CLK),
        .rstn      (RSTN),
        .enable    (active[g]),
        .term      (term[g]),
        .trip      (CMP_TRIP[g]),
        .third_cnt (third_cnt),
        .sixth_cnt (sixth_cnt),
        .sense     (sense_arr[g]),
        .out_level (ch_out[g]),
        .window    (ch_win[g]),
        .held      (held_arr[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PHASE_OUT_1              = ch_out[0];
  assign PHASE_OUT_2              = ch_out[1];
  assign PHASE_OUT_3              = ch_out[2];
  assign PHASE_OUT_4              = ch_out[3];
  assign PHASE_OE_3               = active[2];
  assign PHASE_OE_4               = active[3];
  assign CHANNEL_ACTIVE           = active;
  assign SAMPLE_WINDOW            = ch_win;
  assign SENSED_CHANNEL_CURRENT_1 = held_arr[0];
  assign SENSED_CHANNEL_CURRENT_2 = held_arr[1];
  assign SENSED_CHANNEL_CURRENT_3 = held_arr[2];
  assign SENSED_CHANNEL_CURRENT_4 = held_arr[3];

endmodule

`default_nettype wire

// File: tb/pwm_seq_monitor.sv
// Checker of the phase sequencer top module ports.
// Assumes the period input stays steady from reset release on.
`timescale 1ns/1ps
`default_nettype none

module pwm_seq_monitor
(
  input wire logic                              CLK,
  input wire logic                              RSTN,
  input wire logic [pwm_seq_pkg::PERIOD_W-1:0]  PERIOD_CYCLES,
  input wire logic [3:0]                        CMP_TRIP,
  input wire logic                              PHASE_IN_3,
  input wire logic                              PHASE_IN_4,
  input wire logic                              PHASE_OUT_1,
  input wire logic                              PHASE_OUT_2,
  input wire logic                              PHASE_OUT_3,
  input wire logic                              PHASE_OUT_4,
  input wire logic                              PHASE_OE_3,
  input wire logic                              PHASE_OE_4,
  input wire logic [3:0]                        CHANNEL_ACTIVE,
  input wire logic [3:0]                        SAMPLE_WINDOW,
  input wire logic [pwm_seq_pkg::SENSE_W-1:0]   SENSED_CHANNEL_CURRENT_1,
  input wire logic [pwm_seq_pkg::SENSE_W-1:0]   SENSED_CHANNEL_CURRENT_2,
  input wire logic [pwm_seq_pkg::SENSE_W-1:0]   SENSED_CHANNEL_CURRENT_3,
  input wire logic [pwm_seq_pkg::SENSE_W-1:0]   SENSED_CHANNEL_CURRENT_4
);
  import pwm_seq_pkg::*;
  logic [3:0]         o;
  logic [3:0]         act;
  logic [15:0]        per;
  logic [15:0]        mc;
  logic               st;
  logic [SENSE_W-1:0] hd [4];

  assign o = {PHASE_OUT_4, PHASE_OUT_3, PHASE_OUT_2, PHASE_OUT_1};
  assign hd[0] = SENSED_CHANNEL_CURRENT_1;
  assign hd[1] = SENSED_CHANNEL_CURRENT_2;
  assign hd[2] = SENSED_CHANNEL_CURRENT_3;
  assign hd[3] = SENSED_CHANNEL_CURRENT_4;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  function automatic logic [15:0] fall_at(input int k);
    logic [15:0] f;
    if (act == MASK_4CH)
      f = 16'(3 - k) * (per >> QUARTER_SHIFT);
    else if (act == MASK_3CH)
      f = 16'(2 - k) * (per / THIRD_DIV);
    else
      f = 16'(k) * (per >> HALF_SHIFT);
    return (f + CNT_STEP) % per;
  endfunction

  // ****************************************************************
  // Mode, period and termination phase mirror
  // ****************************************************************
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st  <= 1'b0;
      mc  <= 16'h0000;
      per <= PERIOD_RST;
      act <= 4'h0;
    end
    else if (!st)
    begin
      st  <= 1'b1;
      per <= (PERIOD_CYCLES < MIN_PERIOD) ? MIN_PERIOD : PERIOD_CYCLES;
      act <= PHASE_IN_3 ? MASK_2CH : (PHASE_IN_4 ? MASK_3CH : MASK_4CH);
    end
    else
    begin
      mc <= (mc == per - CNT_STEP) ? 16'h0000 : mc + CNT_STEP;
    end
  end

  a_mask_fixed: assert property (st |-> CHANNEL_ACTIVE == act)
    else $error("active mask differs from captured straps");
  a_oe_drive: assert property (st |-> {PHASE_OE_4, PHASE_OE_3} == act[3:2])
    else $error("pin enables differ from active mask");

  // ****************************************************************
  // Per channel checks
  // ****************************************************************
  for (genvar k = 0; k < 4; k++)
  begin : g_ch
    logic [15:0] lc;
    logic        sn;
    always_ff @(posedge CLK or negedge RSTN)
    begin
      if (!RSTN)
      begin
        lc <= 16'h0000;
        sn <= 1'b0;
      end
      else
      begin
        lc <= o[k] ? 16'h0000 : ((lc == CNT_SAT) ? lc : lc + CNT_STEP);
        if ($fell(o[k]))
          sn <= 1'b1;
      end
    end
    sequence s_ready;
      sn && !o[k] && CMP_TRIP[k] && lc == per / THIRD_DIV;
    endsequence
    sequence s_win_up;
      $rose(SAMPLE_WINDOW[k]) && sn && lc < per;
    endsequence
    a_fall_phase: assert property ($fell(o[k]) |-> mc == fall_at(k))
      else $error("phase output fell at the wrong phase");
    a_min_off: assert property ($rose(o[k]) |-> lc >= per / THIRD_DIV)
      else $error("phase output rose inside forced off time");
    a_rise_trip: assert property (s_ready |=> o[k])
      else $error("phase output ignored a trip after off time");
    a_win_open: assert property (s_win_up |-> lc == per / SIXTH_DIV + 16'h0001)
      else $error("sample window opened at the wrong time");
    a_win_limit: assert property (sn && lc < per && SAMPLE_WINDOW[k] |-> lc <= per / SIXTH_DIV + per / THIRD_DIV)
      else $error("sample window stayed open too long");
    a_hold_sample: assert property ($changed(hd[k]) |-> $past(SAMPLE_WINDOW[k]) || $past(SAMPLE_WINDOW[k], 2) || $past(SAMPLE_WINDOW[k], 3))
      else $error("held sample changed away from a window");
    a_idle_chan: assert property (st && !act[k] |-> !o[k] && !SAMPLE_WINDOW[k] && hd[k] == SAMPLE_RST)
      else $error("unused channel is not idle");
  end
endmodule

`default_nettype wire

// File: tb/phase_driver_model.sv
// Model of the driver chips on the four phase outputs.
// Assumes phase levels and pin enables from the sequencer top module.
`timescale 1ns/1ps
`default_nettype none

module phase_driver_model
(
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic [3:0]                      pwm_in,
  input  wire logic [1:0]                      drive_en,
  input  wire logic [1:0]                      strap_hi,
  output logic [1:0]                           pin_level,
  output logic [pwm_seq_pkg::SENSE_W-1:0]      sense [4],
  output var int                               rise_count
);
  import pwm_seq_pkg::*;
  logic [3:0] prev;

  // Pin driven by the controller, else strapped high or pulled low
  assign pin_level = {drive_en[1] ? pwm_in[3] : strap_hi[1],
                      drive_en[0] ? pwm_in[2] : strap_hi[0]};

  // New current level after each switch-on; open inputs wander
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev <= 4'h0;
      rise_count <= 0;
      for (int k = 0; k < 4; k++)
        sense[k] <= 12'(k) * 12'h139;
    end
    else
    begin
      prev <= pwm_in;
      for (int k = 0; k < 4; k++)
        if (pwm_in[k] && !prev[k])
        begin
          sense[k] <= sense[k] + 12'h2A7 + 12'(k);
          rise_count <= rise_count + 1;
        end
        else if ((k == 3 && |strap_hi) || (k == 2 && strap_hi[0]))
          sense[k] <= sense[k] + 12'h001;
    end
  end
endmodule

`default_nettype wire

// File: tb/multiphase_pwm_sequencer_tb.sv
// Self-checking bench of the phase sequencer with a driver model.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module multiphase_pwm_sequencer_tb;
  import pwm_seq_pkg::*;
  logic                CLK;
  logic                RSTN;
  logic [PERIOD_W-1:0] PERIOD_CYCLES;
  logic [3:0]          CMP_TRIP;
  logic [3:0]          CHANNEL_ACTIVE;
  logic [3:0]          SAMPLE_WINDOW;
  logic [3:0]          o, po, sn, hv, msk;
  logic [1:0]          oe, pin, strap;
  logic [SENSE_W-1:0]  sense [4];
  logic [SENSE_W-1:0]  held [4];
  logic [SENSE_W-1:0]  lowv [4];
  int                  rises, errors, check_count, cyc, per, mode, tmode;
  int                  tf [4];
  int                  nf [4];

  multiphase_pwm_sequencer dut_u
  (
    .CLK(CLK), .RSTN(RSTN), .PERIOD_CYCLES(PERIOD_CYCLES),
    .CMP_TRIP(CMP_TRIP), .PHASE_IN_3(pin[0]), .PHASE_IN_4(pin[1]),
    .CURRENT_SENSE_INPUT_1(sense[0]), .CURRENT_SENSE_INPUT_2(sense[1]),
    .CURRENT_SENSE_INPUT_3(sense[2]), .CURRENT_SENSE_INPUT_4(sense[3]),
    .PHASE_OUT_1(o[0]), .PHASE_OUT_2(o[1]), .PHASE_OUT_3(o[2]),
    .PHASE_OUT_4(o[3]), .PHASE_OE_3(oe[0]), .PHASE_OE_4(oe[1]),
    .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .SAMPLE_WINDOW(SAMPLE_WINDOW),
    .SENSED_CHANNEL_CURRENT_1(held[0]), .SENSED_CHANNEL_CURRENT_2(held[1]),
    .SENSED_CHANNEL_CURRENT_3(held[2]), .SENSED_CHANNEL_CURRENT_4(held[3])
  );

  phase_driver_model drv_u
  (
    .clk(CLK), .rstn(RSTN), .pwm_in(o), .drive_en(oe), .strap_hi(strap),
    .pin_level(pin), .sense(sense), .rise_count(rises)
  );

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  function automatic int off(input int k);
    case (mode)
      4: return (3 - k) * (per >> 2);
      3: return (2 - k) * (per / 3);
      default: return k * (per / 2);
    endcase
  endfunction

  // ****************************************************************
  // Edge monitor: fall phase, off time, held sample
  // ****************************************************************
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      cyc = 0;
      po = 4'h0;
      sn = 4'h0;
      hv = 4'h0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (po[k] && !o[k])
        begin
          if (cyc >= 2 + off(k))
            `CHK("fall phase", 0, (cyc - 2 - off(k)) % per)
          if (hv[k])
            `CHK("held sample", lowv[k], held[k])
          tf[k] = cyc;
          sn[k] = 1'b1;
          nf[k]++;
        end
        if (!po[k] && o[k])
        begin
          `CHK("rise on active", 1'b1, msk[k])
          if (sn[k])
          begin
            `CHK("off time", 1'b1, (cyc - tf[k]) >= per / 3)
            lowv[k] = sense[k];
            hv[k] = 1'b1;
          end
        end
      end
      po = o;
      cyc++;
    end
  end

  task automatic run_test(input logic [1:0] s, input int pc, input int tm);
    @(posedge CLK);
    RSTN <= 1'b0;
    strap <= s;
    PERIOD_CYCLES <= 16'(pc);
    CMP_TRIP <= 4'h0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    tmode = tm;
    per = (pc < 6) ? 6 : pc;
    mode = s[0] ? 2 : (s[1] ? 3 : 4);
    msk = s[0] ? 4'h3 : (s[1] ? 4'h7 : 4'hF);
    nf = '{0, 0, 0, 0};
    repeat (8 * per + 4)
    begin
      @(posedge CLK);
      CMP_TRIP <= (tm == 1) ? 4'hF : ((tm == 2) ? 4'h0 : 4'($urandom));
    end
    @(negedge CLK);
    `CHK("active mask", msk, CHANNEL_ACTIVE)
    `CHK("pin enables", msk[3:2], oe)
    for (int k = 0; k < 4; k++)
      if (!msk[k])
        `CHK("idle held", 12'h000, held[k])
      else if (tm != 2)
        `CHK("falls seen", 1'b1, nf[k] > 3)
    if (tm == 2)
      `CHK("rises", 0, rises)
    $display("Test done: straps %b period %0d trip mode %0d", s, pc, tm);
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    RSTN = 1'b0;
    PERIOD_CYCLES = 16'h000C;
    CMP_TRIP = 4'h0;
    strap = 2'b00;
    errors = 0;
    check_count = 0;
    void'($urandom(32'h10F5));
    run_test(2'b00, 12, 1);
    run_test(2'b00, 16 + $urandom % 25, 0);
    run_test(2'b10, 12, 1);
    run_test(2'b10, 9 + $urandom % 30, 0);
    run_test(2'b01, 6 + $urandom % 30, 0);
    run_test(2'b11, 24, 1);
    run_test(2'b00, 3, 1);
    run_test(2'b10, 18, 2);
    close_out();
  end

  initial
  begin
    #200000;
    errors++;
    close_out();
  end
endmodule

bind multiphase_pwm_sequencer pwm_seq_monitor mon_u
(
  .CLK(CLK), .RSTN(RSTN), .PERIOD_CYCLES(PERIOD_CYCLES),
  .CMP_TRIP(CMP_TRIP), .PHASE_IN_3(PHASE_IN_3), .PHASE_IN_4(PHASE_IN_4),
  .PHASE_OUT_1(PHASE_OUT_1), .PHASE_OUT_2(PHASE_OUT_2),
  .PHASE_OUT_3(PHASE_OUT_3), .PHASE_OUT_4(PHASE_OUT_4),
  .PHASE_OE_3(PHASE_OE_3), .PHASE_OE_4(PHASE_OE_4),
  .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .SAMPLE_WINDOW(SAMPLE_WINDOW),
  .SENSED_CHANNEL_CURRENT_1(SENSED_CHANNEL_CURRENT_1),
  .SENSED_CHANNEL_CURRENT_2(SENSED_CHANNEL_CURRENT_2),
  .SENSED_CHANNEL_CURRENT_3(SENSED_CHANNEL_CURRENT_3),
  .SENSED_CHANNEL_CURRENT_4(SENSED_CHANNEL_CURRENT_4)
);

`default_nettype wire
